// *** flsr_dev.sv ***
// Flash device end: command decode, suspend/resume, software reset, password
// What this block does
// - Hold 64-bit OTP password behind dedicated commands
// - Password unreadable once protection mode selected
// - Program and erase can be suspended, resumed
// - Suspend ready within 20us of suspend
// - Host waits 1ms after resume before suspend
// - Commands taken as 8 single or 2 quad clocks
// - Erase suspend: suspended erase region reads invalid
// - Erase suspend clears latch, filters commands
// - Sector erase suspend waits 20us after start
// - Erase-suspended flag set on suspend, cleared on resume
// - Program-suspended flag set on suspend, cleared on resume
// - Program suspend: suspended program region reads invalid
// - Program suspend clears latch, filters commands
// - Resume opcode alone continues write, clears flags
// - Resume needs no prior write enable
// - Host polls busy or waits nominal time
// - Resume refused while performance enhance active
// - No-operation only cancels a pending reset arm
// - Reset only directly after reset arm
// - Software reset restores volatile power-on state
// - Reset aborts running program or erase
// - Host waits recovery time after reset
// - Reject command not ended on byte boundary
`include "flsr_cfg.svh"
module flsr_dev #(
  parameter int PROG_CYC = `FLSR_PROG_CYC,
  parameter int SERASE_CYC = `FLSR_SERASE_CYC,
  parameter int BERASE_CYC = `FLSR_BERASE_CYC
) (
  flsr_if.dev link,
  input wire logic clk,
  input wire logic rst,
  input wire logic quad_command_mode,
  input wire logic perf_enhance,
  input wire logic password_mode_n,
  output flsr_pkg::flsr_op_t op_kind,
  output logic busy,
  output logic write_enable_latch,
  output logic erase_suspended_flag,
  output logic program_suspended_flag,
  output logic suspend_pending,
  output logic [23:0] suspended_region,
  output logic soft_reset_pulse,
  output logic op_abort_pulse
);
  import flsr_pkg::*;

  logic sclk_s1, sclk_s2, sclk_d;
  logic cs_s1, cs_s2, cs_d;
  logic [3:0] io_s1, io_s2;
  logic [7:0] rx_sh;
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [63:0] rx_data;
  logic [63:0] password_field;
  logic [63:0] tx_sh;
  logic rd_active;
  logic [3:0] io_q, oe_q;
  logic armed;
  logic [31:0] op_timer;
  logic [31:0] elapsed;
  logic [31:0] sus_cnt;

  function automatic logic susp_allowed(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h5a, 8'hc0, 8'h04, 8'h2b,
      8'h9f, 8'haf, 8'h05, 8'hab, 8'h90, 8'hb1, 8'hc1, 8'h35, 8'hf5, 8'h15,
      8'h2d, 8'ha7, 8'he2, 8'he0, 8'h16, `FLSR_OP_WRITE_ENABLE_CMD, `FLSR_OP_SUSPEND,
      `FLSR_OP_RESUME, `FLSR_OP_NOP, `FLSR_OP_RESET_ARM_CMD, `FLSR_OP_RST,
      `FLSR_OP_READ_PASSWORD_CMD: susp_allowed = 1'b1;
      default: susp_allowed = 1'b0;
    endcase
  endfunction

  // Link pins arrive from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      io_s1 <= link.host_io;
      io_s2 <= io_s1;
    end
  end

  logic sclk_rise, sclk_fall, cs_rise, sel;
  logic [2:0] next_bit_cnt;
  logic [7:0] next_byte;
  logic byte_done, suspended, running, exec, gated, do_reset;
  logic start_op, pw_write, sus_req, enter_suspend, resume_ok, op_done;
  assign sclk_rise = sclk_s2 & ~sclk_d;
  assign sclk_fall = ~sclk_s2 & sclk_d;
  assign cs_rise = cs_s2 & ~cs_d;
  assign sel = ~cs_s2;
  // Single-line mode looks at the lowest line only
  assign next_bit_cnt = quad_command_mode ? bit_cnt + 3'h4 : bit_cnt + 3'h1;
  assign next_byte = quad_command_mode ? {rx_sh[3:0], io_s2} : {rx_sh[6:0], io_s2[0]};
  assign byte_done = sclk_rise & sel & (next_bit_cnt == 3'h0);
  assign suspended = erase_suspended_flag | program_suspended_flag;
  assign running = op_kind != FLSR_OP_NONE;
  assign exec = cs_rise & (bit_cnt == 3'h0) & (byte_cnt != 4'h0);
  assign gated = exec & (~suspended | susp_allowed(opcode));
  assign do_reset = gated & (opcode == `FLSR_OP_RST) & armed;
  assign start_op = gated & (byte_cnt == `FLSR_ADDR_BYTES) & write_enable_latch & ~running &
    ((opcode == `FLSR_OP_PROG) | (opcode == `FLSR_OP_SERASE) | (opcode == `FLSR_OP_BERASE));
  assign pw_write = gated & (opcode == `FLSR_OP_WRITE_PASSWORD_CMD) & (byte_cnt == `FLSR_WRITE_PASSWORD_CMD_BYTES) &
    write_enable_latch & password_mode_n & ~running;
  // Suspend without a running operation is dropped
  assign sus_req = gated & (opcode == `FLSR_OP_SUSPEND) & running & ~suspended & ~suspend_pending;
  assign enter_suspend = suspend_pending & (sus_cnt == 32'h0) &
    ((op_kind != FLSR_OP_K_SERASE) || (elapsed >= 32'(`FLSR_SUSP_READY_CYC)));
  // No write enable check on resume
  assign resume_ok = gated & (opcode == `FLSR_OP_RESUME) & suspended & ~perf_enhance;
  assign op_done = running & ~suspended & (op_timer == 32'h1);

  always_ff @(posedge clk) begin
    if (rst || cs_s2) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      rx_sh <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt <= next_bit_cnt;
      rx_sh <= next_byte;
      if (byte_done && byte_cnt != 4'hf) begin
        byte_cnt <= byte_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      opcode <= 8'h00;
      addr <= 24'h0;
      rx_data <= 64'h0;
    end else if (byte_done) begin
      if (byte_cnt == 4'h0) begin
        opcode <= next_byte;
      end else if (byte_cnt < `FLSR_ADDR_BYTES) begin
        addr <= {addr[15:0], next_byte};
      end
      rx_data <= {rx_data[55:0], next_byte};
    end
  end

  // A pending arm dies on any other command, no-operation included
  always_ff @(posedge clk) begin
    if (rst || do_reset) begin
      armed <= 1'b0;
    end else if (exec) begin
      armed <= (opcode == `FLSR_OP_RESET_ARM_CMD);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || do_reset) begin
      write_enable_latch <= 1'b0;
    end else if (enter_suspend || start_op || pw_write) begin
      write_enable_latch <= 1'b0;
    end else if (gated && opcode == `FLSR_OP_WRITE_ENABLE_CMD) begin
      write_enable_latch <= 1'b1;
    end
  end

  // Timer freezes while suspended so resume continues where it stopped
  always_ff @(posedge clk) begin
    if (rst || do_reset) begin
      op_kind <= FLSR_OP_NONE;
      op_timer <= 32'h0;
      elapsed <= 32'h0;
      suspended_region <= 24'h0;
    end else if (start_op) begin
      suspended_region <= addr;
      elapsed <= 32'h0;
      case (opcode)
        `FLSR_OP_PROG: begin
          op_kind <= FLSR_OP_K_PROG;
          op_timer <= 32'(PROG_CYC);
        end
        `FLSR_OP_SERASE: begin
          op_kind <= FLSR_OP_K_SERASE;
          op_timer <= 32'(SERASE_CYC);
        end
        default: begin
          op_kind <= FLSR_OP_K_BERASE;
          op_timer <= 32'(BERASE_CYC);
        end
      endcase
    end else if (op_done) begin
      op_kind <= FLSR_OP_NONE;
      op_timer <= 32'h0;
    end else if (running && !suspended) begin
      op_timer <= op_timer - 32'h1;
      if (elapsed != 32'hffff_ffff) begin
        elapsed <= elapsed + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || do_reset || op_done) begin
      suspend_pending <= 1'b0;
      sus_cnt <= 32'h0;
    end else if (sus_req) begin
      suspend_pending <= 1'b1;
      sus_cnt <= 32'(`FLSR_SUSP_READY_CYC - 1);
    end else if (enter_suspend) begin
      suspend_pending <= 1'b0;
    end else if (suspend_pending && sus_cnt != 32'h0) begin
      sus_cnt <= sus_cnt - 32'h1;
    end
  end

  // The flags mark suspended_region as the one area whose reads are invalid
  always_ff @(posedge clk) begin
    if (rst || do_reset) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end else if (enter_suspend) begin
      erase_suspended_flag <= (op_kind != FLSR_OP_K_PROG);
      program_suspended_flag <= (op_kind == FLSR_OP_K_PROG);
    end else if (resume_ok) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || do_reset) begin
      busy <= 1'b0;
    end else if (start_op || resume_ok) begin
      busy <= 1'b1;
    end else if (op_done || enter_suspend) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
      op_abort_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= do_reset;
      op_abort_pulse <= do_reset & running;
    end
  end

  // Stored value survives software reset; only zeros can be programmed
  always_ff @(posedge clk) begin
    if (rst) begin
      password_field <= `FLSR_PASS_RESET;
    end else if (pw_write) begin
      password_field <= password_field & rx_data;
    end
  end

  // Readout only in single-line timing, one bit per falling clock edge
  always_ff @(posedge clk) begin
    if (rst || cs_s2) begin
      tx_sh <= 64'h0;
      rd_active <= 1'b0;
      io_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (byte_done && byte_cnt == 4'h0 && next_byte == `FLSR_OP_READ_PASSWORD_CMD) begin
      tx_sh <= password_field;
      rd_active <= password_mode_n;
    end else if (sclk_fall && rd_active) begin
      io_q <= {2'b00, tx_sh[63], 1'b0};
      oe_q <= 4'b0010;
      tx_sh <= {tx_sh[62:0], 1'b0};
    end
  end

  assign link.dev_io = io_q;
  assign link.dev_oe = oe_q;
endmodule

// *** flsr_cfg.svh ***
// Opcodes, field positions, host register offsets and timing counts
`ifndef FLSR_CFG_SVH
`define FLSR_CFG_SVH
`define FLSR_OP_WRITE_ENABLE_CMD 8'h06
`define FLSR_OP_PROG 8'h02
`define FLSR_OP_SERASE 8'h20
`define FLSR_OP_BERASE 8'hd8
`define FLSR_OP_SUSPEND 8'hb0
`define FLSR_OP_RESUME 8'h30
`define FLSR_OP_NOP 8'h00
`define FLSR_OP_RESET_ARM_CMD 8'h66
`define FLSR_OP_RST 8'h99
`define FLSR_OP_READ_PASSWORD_CMD 8'h27
`define FLSR_OP_WRITE_PASSWORD_CMD 8'h28
`define FLSR_PASS_BITS 64
`define FLSR_PASS_RESET 64'hffff_ffff_ffff_ffff
`define FLSR_ADDR_BYTES 4'h4
`define FLSR_WRITE_PASSWORD_CMD_BYTES 4'h9
`define FLSR_CLK_MHZ 25
`define FLSR_SUSP_READY_US 20
`define FLSR_SUSP_READY_CYC (`FLSR_SUSP_READY_US * `FLSR_CLK_MHZ)
`define FLSR_RESUME_GAP_MS 1
`define FLSR_RESUME_GAP_CYC (`FLSR_RESUME_GAP_MS * 1000 * `FLSR_CLK_MHZ)
`define FLSR_RECOVERY_CYC 1000
`define FLSR_PROG_CYC 2000
`define FLSR_SERASE_CYC 4000
`define FLSR_BERASE_CYC 8000
`define FLSR_CS_GAP_CYC 8
`define FLSR_REG_CMD 8'h00
`define FLSR_REG_DATA_HI 8'h04
`define FLSR_REG_DATA_LO 8'h08
`define FLSR_REG_STATUS 8'h0c
`define FLSR_REG_RX_HI 8'h10
`define FLSR_REG_RX_LO 8'h14
`define FLSR_REG_CFG 8'h18
`define FLSR_CMD_READ_BIT 12
`define FLSR_ST_REFUSED_BIT 2
`endif

// *** flsr_pkg.sv ***
// Types shared by both ends of the flash command link
package flsr_pkg;
  typedef enum logic [3:0] {
    FLSR_OP_NONE = 4'b0001,
    FLSR_OP_K_PROG = 4'b0010,
    FLSR_OP_K_SERASE = 4'b0100,
    FLSR_OP_K_BERASE = 4'b1000
  } flsr_op_t;
  typedef enum logic [4:0] {
    FLSR_H_IDLE = 5'b00001,
    FLSR_H_SEL = 5'b00010,
    FLSR_H_SHIFT = 5'b00100,
    FLSR_H_DESEL = 5'b01000,
    FLSR_H_WAIT = 5'b10000
  } flsr_hstate_t;
endpackage

// *** flsr_if.sv ***
// Serial/quad command link between host controller and flash
interface flsr_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io;
  logic [3:0] host_oe;
  logic [3:0] dev_io;
  logic [3:0] dev_oe;
  modport host (output sclk, output cs_n, output host_io, output host_oe,
    input dev_io, input dev_oe);
  modport dev (input sclk, input cs_n, input host_io, input host_oe,
    output dev_io, output dev_oe);
endinterface

// *** flsr_host.sv ***
// Host controller end: register port in, serial/quad command frames out
`include "flsr_cfg.svh"
module flsr_host #(
  parameter int RESUME_GAP_CYC = `FLSR_RESUME_GAP_CYC,
  parameter int RECOVERY_CYC = `FLSR_RECOVERY_CYC
) (
  flsr_if.host link,
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import flsr_pkg::*;

  flsr_hstate_t state;
  logic [71:0] tx_sh;
  logic [63:0] rx_sh;
  logic [63:0] rx_word;
  logic [31:0] data_hi, data_lo;
  logic quad;
  logic refused;
  logic [7:0] op;
  logic do_read;
  logic [7:0] tx_cyc, tot_cyc, cyc_cnt;
  logic [2:0] div;
  logic [31:0] hold_cnt, gap_cnt;
  logic sclk_q, cs_q;
  logic [3:0] io_q, oe_q;
  logic io1_s1, io1_s2;

  logic cmd_wr, launch, blocked, idle;
  logic [3:0] nbytes;
  logic [71:0] shifted;
  assign cmd_wr = reg_wr & (reg_addr == `FLSR_REG_CMD);
  assign nbytes = (reg_wdata[11:8] > 4'h8) ? 4'h8 : reg_wdata[11:8];
  assign idle = (state == FLSR_H_IDLE) & (hold_cnt == 32'h0);
  // No suspend inside the gap that follows a resume
  assign blocked = (reg_wdata[7:0] == `FLSR_OP_SUSPEND) & (gap_cnt != 32'h0);
  assign launch = cmd_wr & idle & ~blocked;
  assign shifted = quad ? {tx_sh[67:0], 4'h0} : {tx_sh[70:0], 1'b0};

  always_ff @(posedge clk) begin
    if (rst) begin
      io1_s1 <= 1'b0;
      io1_s2 <= 1'b0;
    end else begin
      io1_s1 <= link.dev_io[1];
      io1_s2 <= io1_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_hi <= 32'h0;
      data_lo <= 32'h0;
      quad <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `FLSR_REG_DATA_HI) begin
        data_hi <= reg_wdata;
      end
      if (reg_addr == `FLSR_REG_DATA_LO) begin
        data_lo <= reg_wdata;
      end
      if (reg_addr == `FLSR_REG_CFG) begin
        quad <= reg_wdata[0];
      end
    end
  end

  // Set wins over the software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (cmd_wr && !launch) begin
      refused <= 1'b1;
    end else if (reg_wr && reg_addr == `FLSR_REG_STATUS && reg_wdata[`FLSR_ST_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // Opcode alone, chip select framed, is a whole resume or reset frame
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FLSR_H_IDLE;
      tx_sh <= 72'h0;
      rx_sh <= 64'h0;
      rx_word <= 64'h0;
      op <= 8'h00;
      do_read <= 1'b0;
      tx_cyc <= 8'h0;
      tot_cyc <= 8'h0;
      cyc_cnt <= 8'h0;
      div <= 3'h0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      io_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      case (state)
        FLSR_H_IDLE: begin
          if (launch) begin
            op <= reg_wdata[7:0];
            do_read <= reg_wdata[`FLSR_CMD_READ_BIT];
            tx_sh <= {reg_wdata[7:0], data_hi, data_lo};
            tx_cyc <= quad ? {3'h0, nbytes + 4'h1, 1'b0} : {1'b0, nbytes + 4'h1, 3'h0};
            tot_cyc <= (quad ? {3'h0, nbytes + 4'h1, 1'b0} : {1'b0, nbytes + 4'h1, 3'h0}) +
              (reg_wdata[`FLSR_CMD_READ_BIT] ? 8'h40 : 8'h00);
            io_q <= quad ? reg_wdata[7:4] : {3'h0, reg_wdata[7]};
            oe_q <= quad ? 4'hf : 4'h1;
            cs_q <= 1'b0;
            cyc_cnt <= 8'h0;
            div <= 3'h0;
            state <= FLSR_H_SEL;
          end
        end
        FLSR_H_SEL: begin
          div <= div + 3'h1;
          if (div == 3'h3) begin
            div <= 3'h0;
            state <= FLSR_H_SHIFT;
          end
        end
        FLSR_H_SHIFT: begin
          div <= div + 3'h1;
          if (div == 3'h3) begin
            sclk_q <= 1'b1;
          end
          if (div == 3'h7) begin
            sclk_q <= 1'b0;
            cyc_cnt <= cyc_cnt + 8'h1;
            tx_sh <= shifted;
            io_q <= quad ? shifted[71:68] : {3'h0, shifted[71]};
            if (cyc_cnt + 8'h1 >= tx_cyc) begin
              oe_q <= 4'h1;
            end
            if (cyc_cnt >= tx_cyc) begin
              rx_sh <= {rx_sh[62:0], io1_s2};
            end
            if (cyc_cnt + 8'h1 == tot_cyc) begin
              state <= FLSR_H_DESEL;
            end
          end
        end
        FLSR_H_DESEL: begin
          div <= div + 3'h1;
          if (div == 3'h3) begin
            cs_q <= 1'b1;
            oe_q <= 4'h0;
            io_q <= 4'h0;
            if (do_read) begin
              rx_word <= rx_sh;
            end
            state <= FLSR_H_WAIT;
          end
        end
        FLSR_H_WAIT: begin
          state <= FLSR_H_IDLE;
        end
        default: begin
          state <= FLSR_H_IDLE;
        end
      endcase
    end
  end

  // Quiet time after each frame; longer after suspend and after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt <= 32'h0;
    end else if (state == FLSR_H_WAIT) begin
      if (op == `FLSR_OP_SUSPEND) begin
        hold_cnt <= 32'(`FLSR_SUSP_READY_CYC);
      end else if (op == `FLSR_OP_RST) begin
        hold_cnt <= 32'(RECOVERY_CYC);
      end else begin
        hold_cnt <= 32'(`FLSR_CS_GAP_CYC);
      end
    end else if (hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_cnt <= 32'h0;
    end else if (state == FLSR_H_WAIT && op == `FLSR_OP_RESUME) begin
      gap_cnt <= 32'(RESUME_GAP_CYC);
    end else if (gap_cnt != 32'h0) begin
      gap_cnt <= gap_cnt - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      case (reg_addr)
        `FLSR_REG_DATA_HI: reg_rdata <= data_hi;
        `FLSR_REG_DATA_LO: reg_rdata <= data_lo;
        `FLSR_REG_STATUS: reg_rdata <= {29'h0, refused, gap_cnt != 32'h0, ~idle};
        `FLSR_REG_RX_HI: reg_rdata <= rx_word[63:32];
        `FLSR_REG_RX_LO: reg_rdata <= rx_word[31:0];
        `FLSR_REG_CFG: reg_rdata <= {31'h0, quad};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.host_io = io_q;
  assign link.host_oe = oe_q;
endmodule

// *** flsr_monitor.sv ***
// Checker for the flash command link and the device suspend and reset state
module flsr_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dev_oe,
  input wire logic password_mode_n,
  input wire logic perf_enhance,
  input wire flsr_pkg::flsr_op_t op_kind,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic erase_suspended_flag,
  input wire logic program_suspended_flag,
  input wire logic suspend_pending,
  input wire logic soft_reset_pulse,
  input wire logic op_abort_pulse
);
  import flsr_pkg::*;
  logic susp;
  assign susp = erase_suspended_flag || program_suspended_flag;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_flags_exclusive: assert property (!(erase_suspended_flag && program_suspended_flag))
    else $error("both suspend flags set");
  a_erase_flag_kind: assert property (erase_suspended_flag |->
    op_kind inside {FLSR_OP_K_SERASE, FLSR_OP_K_BERASE}) else $error("erase flag without erase");
  a_prog_flag_kind: assert property (program_suspended_flag |-> op_kind == FLSR_OP_K_PROG)
    else $error("program flag without program");
  a_suspend_drops_wel: assert property ($rose(susp) |-> !write_enable_latch && !busy)
    else $error("suspend left latch or busy set");
  // Bound covers the sector erase hold-off too; an op that ends first drops the suspend
  a_ready_in_time: assert property ($rose(suspend_pending) |-> ##[1:510]
    (susp || op_kind == FLSR_OP_NONE)) else $error("suspend not ready in time");
  a_perf_blocks_resume: assert property ($fell(susp) && op_kind != FLSR_OP_NONE |->
    !$past(perf_enhance)) else $error("resume taken in performance mode");
  a_reset_restores: assert property (soft_reset_pulse |-> ##[0:1] (op_kind == FLSR_OP_NONE
    && !busy && !write_enable_latch && !susp && !suspend_pending)) else $error("reset left state");
  a_abort_ends_op: assert property (op_abort_pulse |-> ##[0:1] (op_kind == FLSR_OP_NONE && !busy))
    else $error("abort left op running");
  a_busy_has_op: assert property (busy |-> op_kind != FLSR_OP_NONE && !susp)
    else $error("busy without running op");
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock high outside frame");
  a_password_hidden: assert property (!password_mode_n |-> dev_oe == 4'h0)
    else $error("password driven in protection mode");
  c_erase_susp: cover property ($rose(erase_suspended_flag));
  c_prog_susp: cover property ($rose(program_suspended_flag));
  c_soft_reset: cover property (soft_reset_pulse);
endmodule

// *** flsr_tb.sv ***
// Testbench: both link ends, driven through the host register port
`include "flsr_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flsr_pkg::*;
  localparam logic [63:0] pw_val = 64'h0123_4567_89ab_cdef;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic quad_command_mode = 1'b0;
  logic perf_enhance = 1'b0;
  logic password_mode_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  flsr_op_t op_kind;
  logic busy, write_enable_latch, erase_suspended_flag, program_suspended_flag, suspend_pending;
  logic soft_reset_pulse, op_abort_pulse;
  logic [23:0] suspended_region;
  int mismatches = 0, samples_checked = 0, cycles = 0, aborts = 0, resets = 0;
  logic [7:0] edges = 8'h00, last_edges = 8'h00, wshift = 8'h00, last_byte = 8'h00;
  logic sclk_q = 1'b0, cs_q = 1'b1;
  logic [31:0] s;
  logic [63:0] v;
  flsr_if link();
  flsr_host #(.RESUME_GAP_CYC(400), .RECOVERY_CYC(20)) flsr_host_i (.link(link), .clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  flsr_dev #(.PROG_CYC(1200), .SERASE_CYC(700), .BERASE_CYC(800)) flsr_dev_i (.link(link), .clk,
    .rst, .quad_command_mode, .perf_enhance, .password_mode_n, .op_kind, .busy,
    .write_enable_latch, .erase_suspended_flag, .program_suspended_flag, .suspend_pending,
    .suspended_region, .soft_reset_pulse, .op_abort_pulse);
  flsr_monitor flsr_monitor_i (.clk, .rst, .sclk(link.sclk), .cs_n(link.cs_n), .dev_oe(link.dev_oe),
    .password_mode_n, .perf_enhance, .op_kind, .busy, .write_enable_latch, .erase_suspended_flag,
    .program_suspended_flag, .suspend_pending, .soft_reset_pulse, .op_abort_pulse);
  always #20 clk = ~clk;
  // Wire watch: bits per link clock rise, last byte and clock count of each frame
  always @(posedge clk) begin
    sclk_q <= link.sclk;
    cs_q <= link.cs_n;
    if (!link.cs_n && link.sclk && !sclk_q) begin
      edges <= edges + 8'h01;
      wshift <= quad_command_mode ? {wshift[3:0], link.host_io} : {wshift[6:0], link.host_io[0]};
    end
    if (link.cs_n && !cs_q) begin
      last_edges <= edges;
      last_byte <= wshift;
    end
    if (!link.cs_n && cs_q) edges <= 8'h00;
    if (op_abort_pulse) aborts++;
    if (soft_reset_pulse) resets++;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic host_idle;
    logic [31:0] st;
    st = 32'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3000 && st[0] !== 1'b0; i++) reg_read(`FLSR_REG_STATUS, st);
    chk("host idle", 64'h0, st[0]);
    repeat (20) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] op, input logic [3:0] n, input logic [63:0] d, input bit wt);
    reg_write(`FLSR_REG_DATA_HI, d[63:32]);
    reg_write(`FLSR_REG_DATA_LO, d[31:0]);
    reg_write(`FLSR_REG_CMD, {19'h0, op == `FLSR_OP_READ_PASSWORD_CMD, n, op});
    if (wt) host_idle();
  endtask
  task automatic read_pw(output logic [63:0] pw);
    send(`FLSR_OP_READ_PASSWORD_CMD, 4'h0, 64'h0, 1'b1);
    reg_read(`FLSR_REG_RX_HI, pw[63:32]);
    reg_read(`FLSR_REG_RX_LO, pw[31:0]);
  endtask
  task automatic dev_idle;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
    chk("device idle", 64'h0, busy);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reg_read(`FLSR_REG_STATUS, s);
    chk("status", 64'h0, s);
    reg_read(8'h1c, s);
    chk("unmapped", 64'h0, s);
    send(`FLSR_OP_SUSPEND, 4'h0, 64'h0, 1'b1);
    chk("idle suspend", 64'h0, {suspend_pending, program_suspended_flag});
    read_pw(v);
    chk("password reset", `FLSR_PASS_RESET, v);
    send(`FLSR_OP_WRITE_ENABLE_CMD, 4'h0, 64'h0, 1'b1);
    chk("wire byte", 64'h06, last_byte);
    chk("wire clocks", 64'h08, last_edges);
    send(`FLSR_OP_WRITE_PASSWORD_CMD, 4'h8, pw_val, 1'b1);
    read_pw(v);
    chk("password", pw_val, v);
    $display("test reset and password done");
    send(`FLSR_OP_WRITE_ENABLE_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_PROG, 4'h3, {32'h1234_5600, 32'h0}, 1'b1);
    chk("prog running", {FLSR_OP_K_PROG, 1'b1}, {op_kind, busy});
    chk("region", 64'h12_3456, suspended_region);
    send(`FLSR_OP_SUSPEND, 4'h0, 64'h0, 1'b1);
    chk("prog suspend", 64'h4, {program_suspended_flag, write_enable_latch, busy});
    send(`FLSR_OP_SERASE, 4'h3, 64'h0, 1'b1);
    chk("filtered", FLSR_OP_K_PROG, op_kind);
    perf_enhance <= 1'b1;
    send(`FLSR_OP_RESUME, 4'h0, 64'h0, 1'b1);
    chk("perf resume", 64'h1, program_suspended_flag);
    perf_enhance <= 1'b0;
    send(`FLSR_OP_RESUME, 4'h0, 64'h0, 1'b1);
    chk("resume", 64'h1, {program_suspended_flag, busy});
    send(`FLSR_OP_SUSPEND, 4'h0, 64'h0, 1'b1);
    reg_read(`FLSR_REG_STATUS, s);
    chk("gap refused", 64'h6, s[2:0]);
    reg_write(`FLSR_REG_STATUS, 32'h4);
    reg_read(`FLSR_REG_STATUS, s);
    chk("refused clear", 64'h0, s[2]);
    dev_idle();
    $display("test program suspend done");
    send(`FLSR_OP_WRITE_ENABLE_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_SERASE, 4'h3, {32'h00ab_cd00, 32'h0}, 1'b1);
    send(`FLSR_OP_SUSPEND, 4'h0, 64'h0, 1'b0);
    for (int i = 0; i < 200 && suspend_pending !== 1'b1; i++) @(posedge clk);
    repeat (495) @(posedge clk);
    chk("early flag", 64'h0, erase_suspended_flag);
    repeat (10) @(posedge clk);
    chk("erase suspend", 64'h2, {erase_suspended_flag, write_enable_latch});
    chk("erase region", 64'hab_cd, suspended_region);
    host_idle();
    send(`FLSR_OP_RESUME, 4'h0, 64'h0, 1'b1);
    chk("erase resume", 64'h0, erase_suspended_flag);
    dev_idle();
    $display("test erase suspend done");
    send(`FLSR_OP_WRITE_ENABLE_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_BERASE, 4'h3, 64'h0, 1'b1);
    send(`FLSR_OP_RESET_ARM_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_NOP, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_RST, 4'h0, 64'h0, 1'b1);
    chk("reset cancelled", {FLSR_OP_K_BERASE, 1'b1}, {op_kind, busy});
    send(`FLSR_OP_RESET_ARM_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_RST, 4'h0, 64'h0, 1'b1);
    chk("reset state", {FLSR_OP_NONE, 2'b00}, {op_kind, busy, write_enable_latch});
    chk("abort", 64'h11, {aborts[3:0], resets[3:0]});
    $display("test soft reset done");
    reg_write(`FLSR_REG_CFG, 32'h1);
    quad_command_mode <= 1'b1;
    send(`FLSR_OP_WRITE_ENABLE_CMD, 4'h0, 64'h0, 1'b1);
    chk("quad latch", 64'h1, write_enable_latch);
    chk("quad wire", 64'h0206, {last_edges, last_byte});
    send(`FLSR_OP_RESET_ARM_CMD, 4'h0, 64'h0, 1'b1);
    send(`FLSR_OP_RST, 4'h0, 64'h0, 1'b1);
    chk("quad reset", 64'h0, write_enable_latch);
    reg_write(`FLSR_REG_CFG, 32'h0);
    quad_command_mode <= 1'b0;
    read_pw(v);
    chk("password kept", pw_val, v);
    password_mode_n <= 1'b0;
    read_pw(v);
    chk("password hidden", 64'h1, v !== pw_val);
    $display("test quad and protection done");
    report_and_stop();
  end
endmodule
